// ### design/csr_pkg.sv
// Constants and types for the charge and supply readout block.
// Assumes a classic Wishbone slave with 32-bit data and word-aligned registers.
package csr_pkg;

   localparam int ADR_W = 10;
   localparam int IDX_W = 8;

   // Register indices; the byte address is four times the index.
   localparam logic [7:0] IDX_CHG_HIGH = 8'h19;
   localparam logic [7:0] IDX_CHG_LOW = 8'h1A;
   localparam logic [7:0] IDX_AVG_HIGH = 8'h1B;
   localparam logic [7:0] IDX_AVG_LOW = 8'h1C;
   localparam logic [7:0] IDX_CONTROL = 8'h30;
   localparam logic [7:0] IDX_STATUS = 8'h31;

   // Control register fields.
   localparam int CTL_PRESC_LSB = 0;
   localparam int CTL_TAU_LSB = 4;
   localparam int CTL_SEC_BIT = 7;
   localparam int CTL_CLEAR_BIT = 8;

   // Status register fields.
   localparam int STA_CAL_ACT_BIT = 0;
   localparam int STA_CAL_RES_BIT = 1;
   localparam int STA_PIN_A_BIT = 2;

   localparam int FRAC_W = 8;
   localparam int VOLT_W = 12;
   localparam int ACC_W = VOLT_W + FRAC_W;

   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_COUNT = 16'h0000;
   localparam logic [3:0] RST_PRESC = 4'h0;
   localparam logic [3:0] RST_PRESC_CNT = 4'h0;
   localparam logic [2:0] RST_TAU = 3'h4;
   localparam logic [ACC_W-1:0] RST_ACC = 20'h0_0000;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   typedef struct packed {
      logic sec_supply;
      logic [2:0] tau;
      logic [3:0] presc;
   } csr_ctrl_t;

   typedef enum logic [1:0] {
      CSR_CHARGE = 2'b00,
      CSR_CALIB = 2'b01,
      CSR_RESULT = 2'b10
   } csr_mode_t;

endpackage

// ### design/csr_readout.sv
// Charge counter high and low bytes and filtered average supply readout with Wishbone access.
// Assumes pulse, reference clock and calibration inputs are asynchronous and the
// voltage samples arrive on clk_i from the converter logic.
//
// Function
// - Read-only register holds charge count low byte.
// - Calibration makes counter count 10 MHz cycles.
// - After calibration, bytes return cycle count until clear.
// - Addressing a measurement register suspends its update.
// - High-byte read copies low byte into shadow.
// - High nibble register holds average bits 11:8.
// - Average uses IIR filter with settable constant.
// - Measure pin A when secondary supply present.
// - Code is high nibble shifted eight plus low.
// - Low byte register holds average bits 7:0.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/10ps

module csr_readout (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [csr_pkg::ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic pfm_pulse_i,
   input wire logic ref_clk_10m_i,
   input wire logic cal_active_i,
   input wire logic [csr_pkg::VOLT_W-1:0] sample_i,
   input wire logic sample_valid_i,
   output logic measure_pin_a_o
);

   function automatic logic rising(input logic now, input logic prev);
      rising = now & ~prev;
   endfunction

   function automatic logic falling(input logic now, input logic prev);
      falling = ~now & prev;
   endfunction

   // Pair decodes used by the update hold; the read logic decodes each index on its own.
   function automatic logic is_chg_pair(input logic [csr_pkg::IDX_W-1:0] i);
      is_chg_pair = (i == csr_pkg::IDX_CHG_HIGH) | (i == csr_pkg::IDX_CHG_LOW);
   endfunction

   function automatic logic is_avg_pair(input logic [csr_pkg::IDX_W-1:0] i);
      is_avg_pair = (i == csr_pkg::IDX_AVG_HIGH) | (i == csr_pkg::IDX_AVG_LOW);
   endfunction

   // One filter step; the fraction bits keep small steps from vanishing at large time constants.
   function automatic logic [csr_pkg::ACC_W-1:0] iir_step(
      input logic [csr_pkg::ACC_W-1:0] acc,
      input logic [csr_pkg::VOLT_W-1:0] smp,
      input logic [2:0] tau
   );
      logic [csr_pkg::ACC_W-1:0] tgt;
      tgt = {smp, {csr_pkg::FRAC_W{1'b0}}};
      iir_step = acc - (acc >> tau) + (tgt >> tau);
   endfunction

   // Control read word; the clear bit is a strobe and always reads zero.
   function automatic logic [31:0] ctrl_word(input csr_pkg::csr_ctrl_t c);
      logic [31:0] w;
      w = csr_pkg::RST_WORD;
      w[csr_pkg::CTL_PRESC_LSB +: 4] = c.presc;
      w[csr_pkg::CTL_TAU_LSB +: 3] = c.tau;
      w[csr_pkg::CTL_SEC_BIT] = c.sec_supply;
      ctrl_word = w;
   endfunction

   // Status read word built from the counter mode and the pin selection.
   function automatic logic [31:0] status_word(input csr_pkg::csr_mode_t m, input logic sec);
      logic [31:0] w;
      w = csr_pkg::RST_WORD;
      w[csr_pkg::STA_CAL_ACT_BIT] = (m == csr_pkg::CSR_CALIB);
      w[csr_pkg::STA_CAL_RES_BIT] = (m == csr_pkg::CSR_RESULT);
      w[csr_pkg::STA_PIN_A_BIT] = sec;
      status_word = w;
   endfunction

   logic [csr_pkg::IDX_W-1:0] idx;
   logic req;
   logic rd_take;
   logic wr_take;
   logic ack_q;
   logic [31:0] dat_q;

   logic [2:0] pfm_sync_q;
   logic [2:0] ref_sync_q;
   logic [2:0] cal_sync_q;
   logic pfm_edge;
   logic ref_edge;
   logic cal_start;
   logic cal_end;

   csr_pkg::csr_ctrl_t ctrl_q;
   logic clear_q;
   csr_pkg::csr_mode_t mode_q;
   logic [3:0] presc_cnt_q;
   logic presc_tick;
   logic [15:0] count_q;
   logic [7:0] chg_shadow_q;
   logic chg_hold;

   logic [csr_pkg::ACC_W-1:0] acc_q;
   logic [csr_pkg::ACC_W-1:0] acc_d;
   logic [csr_pkg::VOLT_W-1:0] avg;
   logic [7:0] avg_shadow_q;
   logic avg_hold;

   assign idx = adr_i[csr_pkg::IDX_W+1:2];
   assign req = cyc_i & stb_i;
   assign rd_take = req & ~we_i & ~ack_q;
   assign wr_take = req & we_i & ~ack_q;

   // Addressing either byte of a pair freezes that value for the whole access.
   // A long hold loses counts, so the host should keep the address up only while reading.
   assign chg_hold = req & is_chg_pair(idx);
   assign avg_hold = req & is_avg_pair(idx);

   // Two flip-flops, then a third stage kept only for edge detection.
   // The idle level of every pin is low and all stages reset low, so no false edge follows reset.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pfm_sync_q <= 3'h0;
      end else begin
         pfm_sync_q <= {pfm_sync_q[1:0], pfm_pulse_i};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_sync_q <= 3'h0;
      end else begin
         ref_sync_q <= {ref_sync_q[1:0], ref_clk_10m_i};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cal_sync_q <= 3'h0;
      end else begin
         cal_sync_q <= {cal_sync_q[1:0], cal_active_i};
      end
   end

   assign pfm_edge = rising(pfm_sync_q[1], pfm_sync_q[2]);
   assign ref_edge = rising(ref_sync_q[1], ref_sync_q[2]);
   assign cal_start = rising(cal_sync_q[1], cal_sync_q[2]);
   assign cal_end = falling(cal_sync_q[1], cal_sync_q[2]);

   // Bus slave: one wait state, ack drops in the cycle after it was given.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_q <= csr_pkg::RST_WORD;
      end else if (rd_take) begin
         dat_q <= csr_pkg::RST_WORD;
         unique case (idx)
            csr_pkg::IDX_CHG_HIGH: dat_q[7:0] <= count_q[15:8];
            csr_pkg::IDX_CHG_LOW: dat_q[7:0] <= chg_shadow_q;
            csr_pkg::IDX_AVG_HIGH: dat_q[3:0] <= avg[11:8];
            csr_pkg::IDX_AVG_LOW: dat_q[7:0] <= avg_shadow_q;
            csr_pkg::IDX_CONTROL: dat_q <= ctrl_word(ctrl_q);
            csr_pkg::IDX_STATUS: dat_q <= status_word(mode_q, ctrl_q.sec_supply);
            default: dat_q <= csr_pkg::RST_WORD;
         endcase
      end
   end

   assign ack_o = ack_q;
   assign dat_o = dat_q;

   // Control writes honour byte lanes.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= '{sec_supply: 1'b0, tau: csr_pkg::RST_TAU, presc: csr_pkg::RST_PRESC};
      end else if (wr_take && idx == csr_pkg::IDX_CONTROL && sel_i[0]) begin
         ctrl_q.presc <= dat_i[csr_pkg::CTL_PRESC_LSB +: 4];
         ctrl_q.tau <= dat_i[csr_pkg::CTL_TAU_LSB +: 3];
         ctrl_q.sec_supply <= dat_i[csr_pkg::CTL_SEC_BIT];
      end
   end

   // The clear bit acts for one cycle per accepted write; a bus held past ack is taken again every other cycle and clears again.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clear_q <= 1'b0;
      end else if (wr_take && idx == csr_pkg::IDX_CONTROL && sel_i[1]) begin
         clear_q <= dat_i[csr_pkg::CTL_CLEAR_BIT];
      end else begin
         clear_q <= 1'b0;
      end
   end

   assign measure_pin_a_o = ctrl_q.sec_supply;

   // Counter mode: charge counting, calibration, or holding a calibration result.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_q <= csr_pkg::CSR_CHARGE;
      end else begin
         unique case (mode_q)
            csr_pkg::CSR_CHARGE: begin
               if (cal_start) begin
                  mode_q <= csr_pkg::CSR_CALIB;
               end
            end
            csr_pkg::CSR_CALIB: begin
               if (cal_end) begin
                  mode_q <= csr_pkg::CSR_RESULT;
               end
            end
            csr_pkg::CSR_RESULT: begin
               if (cal_start) begin
                  mode_q <= csr_pkg::CSR_CALIB;
               end else if (clear_q) begin
                  mode_q <= csr_pkg::CSR_CHARGE;
               end
            end
            default: mode_q <= csr_pkg::CSR_CHARGE;
         endcase
      end
   end

   // Prescaler: one count every presc+1 pulses; pulses keep counting while held.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         presc_cnt_q <= csr_pkg::RST_PRESC_CNT;
      end else if (clear_q || mode_q != csr_pkg::CSR_CHARGE) begin
         presc_cnt_q <= csr_pkg::RST_PRESC_CNT;
      end else if (pfm_edge) begin
         presc_cnt_q <= presc_tick ? csr_pkg::RST_PRESC_CNT : presc_cnt_q + 4'h1;
      end
   end

   assign presc_tick = pfm_edge & (presc_cnt_q == ctrl_q.presc);

   // A calibration starts from zero, so any charge count is overwritten.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_q <= csr_pkg::RST_COUNT;
      end else if (clear_q && mode_q != csr_pkg::CSR_CALIB) begin
         count_q <= csr_pkg::RST_COUNT;
      end else if (cal_start) begin
         count_q <= csr_pkg::RST_COUNT;
      end else if (!chg_hold) begin
         unique case (mode_q)
            csr_pkg::CSR_CHARGE: begin
               if (presc_tick) begin
                  count_q <= count_q + 16'h0001;
               end
            end
            csr_pkg::CSR_CALIB: begin
               if (ref_edge) begin
                  count_q <= count_q + 16'h0001;
               end
            end
            csr_pkg::CSR_RESULT: count_q <= count_q;
            default: count_q <= count_q;
         endcase
      end
   end

   // High-byte reads snapshot the low byte so the pair stays coherent.
   // A low-byte read without a high-byte read first returns the old snapshot.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chg_shadow_q <= csr_pkg::RST_BYTE;
      end else if (rd_take && idx == csr_pkg::IDX_CHG_HIGH) begin
         chg_shadow_q <= count_q[7:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         avg_shadow_q <= csr_pkg::RST_BYTE;
      end else if (rd_take && idx == csr_pkg::IDX_AVG_HIGH) begin
         avg_shadow_q <= avg[7:0];
      end
   end

   // First-order low-pass: acc += (sample - acc) / 2^tau, with fraction bits.
   always_comb begin
      acc_d = iir_step(acc_q, sample_i, ctrl_q.tau);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc_q <= csr_pkg::RST_ACC;
      end else if (clear_q) begin
         acc_q <= csr_pkg::RST_ACC;
      end else if (sample_valid_i && !avg_hold) begin
         acc_q <= acc_d;
      end
   end

   assign avg = acc_q[csr_pkg::ACC_W-1:csr_pkg::FRAC_W];

endmodule // csr_readout

// ### sim/csr_readout_chk.sv
// Concurrent checks on the readout block's bus answers and readout fields.
// Assumes it is bound to csr_readout and sees only that module's ports.
`timescale 1ns/10ps
module csr_readout_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [csr_pkg::ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic measure_pin_a_o
);
   wire take = cyc_i & stb_i & ~ack_o;
   wire rd = take & ~we_i;
   wire [7:0] idx = adr_i[9:2];
   logic ok_q;
   logic lr_q;
   logic [7:0] low_q;
   logic [2:0] ctl_q;
   // Remembers the last low-byte answer until the next high-nibble read refreshes the shadow.
   always_ff @(posedge clk_i) begin
      lr_q <= ~rst_i & rd & (idx == csr_pkg::IDX_AVG_LOW);
      ctl_q <= rst_i ? 3'h0 : {ctl_q[1:0], take & we_i & sel_i[0] & (idx == csr_pkg::IDX_CONTROL)};
      if (lr_q) low_q <= dat_o[7:0];
      if (rst_i || (rd && idx == csr_pkg::IDX_AVG_HIGH)) ok_q <= 1'b0;
      else if (lr_q) ok_q <= 1'b1;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_rd(logic [7:0] i);
      rd && idx == i;
   endsequence
   sequence s_answer;
      ack_o ##1 !ack_o;
   endsequence
   chk_ack_pulse: assert property (take |=> s_answer) else $error("ack is not one pulse after request");
   chk_ack_cause: assert property ($rose(ack_o) |-> $past(take)) else $error("ack without request");
   chk_chg_low: assert property (s_rd(csr_pkg::IDX_CHG_LOW) |=> dat_o[31:8] == 24'h00_0000)
      else $error("charge low read has upper bits set");
   chk_chg_high: assert property (s_rd(csr_pkg::IDX_CHG_HIGH) |=> dat_o[31:8] == 24'h00_0000)
      else $error("charge high read has upper bits set");
   chk_avg_nibble: assert property (s_rd(csr_pkg::IDX_AVG_HIGH) |=> dat_o[31:4] == 28'h000_0000)
      else $error("average high read has reserved bits set");
   chk_avg_low: assert property (s_rd(csr_pkg::IDX_AVG_LOW) |=> dat_o[31:8] == 24'h00_0000)
      else $error("average low read has upper bits set");
   chk_dat_hold: assert property (!$past(rd) |-> $stable(dat_o)) else $error("read data moved without a read");
   chk_shadow_kept: assert property (s_rd(csr_pkg::IDX_AVG_LOW) ##0 ok_q |=> dat_o[7:0] == low_q)
      else $error("low byte changed without a high read");
   chk_pin_cause: assert property ($changed(measure_pin_a_o) |-> |ctl_q)
      else $error("pin select moved without control write");
endmodule // csr_readout_chk

bind csr_readout csr_readout_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .measure_pin_a_o(measure_pin_a_o));

// ### sim/csr_readout_tb.sv
// Self-checking bench for the charge and supply readout block.
// Assumes the checker is bound in and the bench acts as Wishbone master.
`timescale 1ns/10ps
module csr_readout_tb;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, pfm_pulse_i = 0, ref_clk_10m_i = 0, ref_en = 0;
   logic cal_active_i = 0, sample_valid_i = 0, measure_pin_a_o, ack_o;
   logic [9:0] adr_i = 10'h000;
   logic [3:0] sel_i = 4'hF;
   logic [31:0] dat_i = 32'h0000_0000, dat_o, q;
   logic [11:0] sample_i = 12'h000;
   logic [15:0] cal_v;
   int error_cnt = 0, check_count = 0;
   always #25 clk_i = ~clk_i;
   always @(posedge clk_i) if (ref_en) ref_clk_10m_i <= ~ref_clk_10m_i;
   csr_readout uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pfm_pulse_i(pfm_pulse_i),
      .ref_clk_10m_i(ref_clk_10m_i), .cal_active_i(cal_active_i), .sample_i(sample_i),
      .sample_valid_i(sample_valid_i), .measure_pin_a_o(measure_pin_a_o));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Holds the request until ack is sampled, then takes the data and releases.
   task automatic bus(input logic [7:0] idx, input logic we, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= we;
      adr_i <= {idx, 2'b00};
      dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      if (n >= 50) begin
         error_cnt++;
         results();
      end
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] idx, input logic [11:0] exp, input string what);
      bus(idx, 1'b0, 32'h0000_0000);
      chk(q, {20'h0_0000, exp}, what);
   endtask
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge clk_i) pfm_pulse_i <= 1'b1;
         repeat (3) @(posedge clk_i);
         pfm_pulse_i <= 1'b0;
         repeat (3) @(posedge clk_i);
      end
   endtask
   task automatic send(input logic [11:0] s);
      @(posedge clk_i) sample_i <= s;
      sample_valid_i <= 1'b1;
      @(posedge clk_i) sample_valid_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask
   task automatic t_reset();
      rd(csr_pkg::IDX_CHG_HIGH, 12'h000, "charge high");
      rd(csr_pkg::IDX_AVG_HIGH, 12'h000, "avg high");
      rd(csr_pkg::IDX_AVG_LOW, 12'h000, "avg low");
      rd(csr_pkg::IDX_CONTROL, 12'h040, "control");
      bus(csr_pkg::IDX_CHG_LOW, 1'b1, 32'h0000_000F);
      bus(csr_pkg::IDX_AVG_HIGH, 1'b1, 32'h0000_000F);
      rd(csr_pkg::IDX_CHG_LOW, 12'h000, "charge low ro");
      rd(csr_pkg::IDX_AVG_HIGH, 12'h000, "avg high ro");
      rd(8'h55, 12'h000, "unmapped");
      $display("test reset done");
   endtask
   task automatic t_charge();
      pulses(5);
      rd(csr_pkg::IDX_CHG_HIGH, 12'h000, "count high");
      rd(csr_pkg::IDX_CHG_LOW, 12'h005, "count low");
      bus(csr_pkg::IDX_CONTROL, 1'b1, 32'h0000_0141);
      pulses(6);
      rd(csr_pkg::IDX_CHG_HIGH, 12'h000, "scaled high");
      pulses(2);
      rd(csr_pkg::IDX_CHG_LOW, 12'h003, "shadow low");
      rd(csr_pkg::IDX_CHG_HIGH, 12'h000, "scaled high");
      rd(csr_pkg::IDX_CHG_LOW, 12'h004, "scaled low");
      $display("test charge done");
   endtask
   task automatic t_cal();
      rd(csr_pkg::IDX_CHG_HIGH, 12'h000, "saved high");
      rd(csr_pkg::IDX_CHG_LOW, 12'h004, "saved low");
      ref_en <= 1'b1;
      @(posedge clk_i) cal_active_i <= 1'b1;
      repeat (80) @(posedge clk_i);
      cal_active_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      ref_en <= 1'b0;
      bus(csr_pkg::IDX_CHG_HIGH, 1'b0, 32'h0000_0000);
      cal_v[15:8] = q[7:0];
      bus(csr_pkg::IDX_CHG_LOW, 1'b0, 32'h0000_0000);
      cal_v[7:0] = q[7:0];
      chk(32'(cal_v inside {[16'h0026:16'h002A]}), 32'h0000_0001, "cal cycles");
      pulses(3);
      rd(csr_pkg::IDX_CHG_HIGH, {4'h0, cal_v[15:8]}, "held high");
      rd(csr_pkg::IDX_CHG_LOW, {4'h0, cal_v[7:0]}, "held low");
      rd(csr_pkg::IDX_STATUS, 12'h002, "status result");
      bus(csr_pkg::IDX_CONTROL, 1'b1, 32'h0000_0140);
      rd(csr_pkg::IDX_CHG_HIGH, 12'h000, "cleared high");
      rd(csr_pkg::IDX_CHG_LOW, 12'h000, "cleared low");
      $display("test calibration done");
   endtask
   task automatic t_avg();
      bus(csr_pkg::IDX_CONTROL, 1'b1, 32'h0000_0000);
      send(12'hABC);
      rd(csr_pkg::IDX_AVG_HIGH, 12'h00A, "avg nibble");
      rd(csr_pkg::IDX_AVG_LOW, 12'h0BC, "avg byte");
      bus(csr_pkg::IDX_CONTROL, 1'b1, 32'h0000_0010);
      send(12'h000);
      rd(csr_pkg::IDX_AVG_HIGH, 12'h005, "filtered nibble");
      bus(csr_pkg::IDX_CONTROL, 1'b1, 32'h0000_0000);
      send(12'hFFF);
      rd(csr_pkg::IDX_AVG_LOW, 12'h05E, "avg shadow");
      rd(csr_pkg::IDX_AVG_HIGH, 12'h00F, "new nibble");
      rd(csr_pkg::IDX_AVG_LOW, 12'h0FF, "new byte");
      send(12'h000);
      rd(csr_pkg::IDX_AVG_LOW, 12'h0FF, "byte again");
      $display("test average done");
   endtask
   task automatic t_pin();
      bus(csr_pkg::IDX_CONTROL, 1'b1, 32'h0000_0080);
      repeat (3) @(posedge clk_i);
      chk({31'h0000_0000, measure_pin_a_o}, 32'h0000_0001, "pin a");
      rd(csr_pkg::IDX_STATUS, 12'h004, "status");
      bus(csr_pkg::IDX_CONTROL, 1'b1, 32'h0000_0000);
      repeat (3) @(posedge clk_i);
      chk({31'h0000_0000, measure_pin_a_o}, 32'h0000_0000, "pin b");
      $display("test pin select done");
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_charge();
      t_cal();
      t_avg();
      t_pin();
      results();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      results();
   end
endmodule // csr_readout_tb
